/* File: bench/bsw_ctl_model.sv */
// Memory controller model driving the burst port of the SRAM core.
// Assumes tasks are called just after a rising edge of CLK.
`timescale 1ns/100ps
`default_nettype none
module bsw_ctl_model
   import bsw_pkg::*;
(
   input  wire logic                  CLK,
   input  wire logic                  LOAD_READY,
   output logic                       LOAD_REQUEST_N,
   output logic                       READ_WRITE,
   output logic [BSW_ADDR_W-1:0]      WORD_ADDRESS,
   output logic                       BURST_ORDER_BIT,
   output logic [1:0]                 EXPANSION_ADDR,
   output logic [BSW_DATA_W-1:0]      WRITE_DATA,
   output logic [1:0]                 BYTE_WRITE_SELECT_N
);
   initial begin
      LOAD_REQUEST_N = 1'b1;
      READ_WRITE = 1'b1;
      WORD_ADDRESS = '0;
      BURST_ORDER_BIT = 1'b0;
      EXPANSION_ADDR = 2'h0;
      WRITE_DATA = '0;
      BYTE_WRITE_SELECT_N = 2'h3;
   end
   // Returns after the second beat, so calls may follow back to back.
   task automatic burst(input logic rw, input logic [5:0] a,
         input logic o, input logic [1:0] ex, input logic [17:0] d0,
         input logic [1:0] s0, input logic [17:0] d1, input logic [1:0] s1);
      LOAD_REQUEST_N <= 1'b0;
      READ_WRITE <= rw;
      WORD_ADDRESS <= a;
      BURST_ORDER_BIT <= o;
      EXPANSION_ADDR <= ex;
      WRITE_DATA <= d0;
      BYTE_WRITE_SELECT_N <= s0;
      do @(negedge CLK); while (LOAD_READY !== 1'b1);
      @(posedge CLK);
      LOAD_REQUEST_N <= 1'b1;
      READ_WRITE <= ~rw;
      WORD_ADDRESS <= ~a;
      EXPANSION_ADDR <= 2'h0;
      WRITE_DATA <= d1;
      BYTE_WRITE_SELECT_N <= s1;
      @(posedge CLK);
   endtask
endmodule
`default_nettype wire

/* File: bench/bsw_top_asserts.sv */
// Concurrent checks on the burst port of the SRAM core.
// Assumes one clock and the synchronous active-low reset of the core.
`timescale 1ns/100ps
`default_nettype none
module bsw_top_asserts
   import bsw_pkg::*;
#(
   parameter int DATA_W = BSW_DATA_W,
   parameter int LANE_W = BSW_LANE_W,
   parameter int ADDR_W = BSW_ADDR_W
) (
   input wire logic                       CLK,
   input wire logic                       RST_B,
   input wire logic                       LOAD_REQUEST_N,
   input wire logic                       READ_WRITE,
   input wire logic [ADDR_W-1:0]          WORD_ADDRESS,
   input wire logic                       BURST_ORDER_BIT,
   input wire logic [DATA_W-1:0]          WRITE_DATA,
   input wire logic [DATA_W/LANE_W-1:0]   BYTE_WRITE_SELECT_N,
   input wire logic                       LOAD_READY,
   input wire logic [DATA_W-1:0]          RD_DATA,
   input wire logic                       RD_VALID,
   input wire logic                       RD_READY
);
   // Forwarding checks need an empty buffer so the head is the new word.
   wire logic take = !LOAD_REQUEST_N && LOAD_READY;
   wire logic sel0 = BYTE_WRITE_SELECT_N == '0;
   wire logic wfw  = take && !READ_WRITE && sel0;
   wire logic rfw  = take && READ_WRITE && !RD_VALID;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   a_load_gap: assert property (take |=> !LOAD_READY)
      else $error("load accepted on second beat");
   a_read_lat: assert property (take && READ_WRITE && !RD_VALID
      |-> ##2 RD_VALID) else $error("read data late");
   a_wr_nopush: assert property (take && !READ_WRITE && !RD_VALID
      |=> !RD_VALID [*2]) else $error("write produced read data");
   a_rd_hold: assert property (RD_VALID && !RD_READY
      |=> RD_VALID && $stable(RD_DATA)) else $error("read word dropped");
   a_fwd_first: assert property (rfw && !BURST_ORDER_BIT
      && $past(wfw, 2) && !$past(BURST_ORDER_BIT, 2)
      && $past(WORD_ADDRESS, 2) == WORD_ADDRESS
      |-> ##2 RD_DATA == $past(WRITE_DATA, 4))
      else $error("first beat not forwarded");
   a_fwd_second: assert property (rfw && BURST_ORDER_BIT
      && $past(wfw, 2) && !$past(BURST_ORDER_BIT, 2) && $past(sel0)
      && $past(WORD_ADDRESS, 2) == WORD_ADDRESS
      |-> ##2 RD_DATA == $past(WRITE_DATA, 3))
      else $error("second beat not forwarded");
   a_fwd_swap: assert property (rfw && BURST_ORDER_BIT
      && $past(wfw, 2) && $past(BURST_ORDER_BIT, 2)
      && $past(WORD_ADDRESS, 2) == WORD_ADDRESS
      |-> ##2 RD_DATA == $past(WRITE_DATA, 4))
      else $error("burst order wrong");
   a_reset_idle: assert property ($rose(RST_B)
      |-> LOAD_READY && !RD_VALID) else $error("not idle after reset");
endmodule
bind bsw_top bsw_top_asserts #(.DATA_W(DATA_W), .LANE_W(LANE_W),
   .ADDR_W(ADDR_W)) u_chk (.CLK, .RST_B, .LOAD_REQUEST_N, .READ_WRITE,
   .WORD_ADDRESS, .BURST_ORDER_BIT, .WRITE_DATA, .BYTE_WRITE_SELECT_N,
   .LOAD_READY, .RD_DATA, .RD_VALID, .RD_READY);
`default_nettype wire

/* File: bench/tb_bsw_top.sv */
// Self-checking bench for the burst SRAM core and its register slave.
// Assumes the controller model and the bound checker are compiled.
`timescale 1ns/100ps
`default_nettype none
module tb_bsw_top
   import bsw_pkg::*;
;
   logic        CLK = 1'b0, RST_B = 1'b0, RD_READY = 1'b0;
   logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
   logic        S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0;
   logic        S_AXI_RREADY = 1'b0;
   logic [3:0]  S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0;
   logic [3:0]  S_AXI_WSTRB = 4'hf;
   logic [31:0] S_AXI_WDATA = 32'h0;
   wire logic   S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
   wire logic   S_AXI_RVALID, LOAD_READY, RD_VALID, LOAD_REQUEST_N;
   wire logic   READ_WRITE, BURST_ORDER_BIT;
   wire logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, EXPANSION_ADDR;
   wire logic [1:0]  BYTE_WRITE_SELECT_N;
   wire logic [31:0] S_AXI_RDATA;
   wire logic [17:0] RD_DATA, WRITE_DATA;
   wire logic [5:0]  WORD_ADDRESS;
   int          error_cnt = 0, compares = 0, cyc = 0;
   logic [17:0] mem [64][2];
   logic [17:0] expq [$];
   always #2 CLK = ~CLK;
   bsw_top DUT (.CLK, .RST_B, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
      .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
      .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
      .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
      .S_AXI_RREADY, .LOAD_REQUEST_N, .READ_WRITE, .WORD_ADDRESS,
      .BURST_ORDER_BIT, .EXPANSION_ADDR, .WRITE_DATA, .BYTE_WRITE_SELECT_N,
      .LOAD_READY, .RD_DATA, .RD_VALID, .RD_READY);
   bsw_ctl_model ctl (.CLK, .LOAD_READY, .LOAD_REQUEST_N, .READ_WRITE,
      .WORD_ADDRESS, .BURST_ORDER_BIT, .EXPANSION_ADDR, .WRITE_DATA,
      .BYTE_WRITE_SELECT_N);
   ////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      logic pa = 1'b1;
      logic pw = 1'b1;
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      while (pa || pw) begin
         @(negedge CLK);
         pa = pa && S_AXI_AWREADY !== 1'b1;
         pw = pw && S_AXI_WREADY !== 1'b1;
         @(posedge CLK);
         if (!pa) S_AXI_AWVALID <= 1'b0;
         if (!pw) S_AXI_WVALID <= 1'b0;
      end
      do @(negedge CLK); while (S_AXI_BVALID !== 1'b1);
      chk(32'(S_AXI_BRESP), 32'(BSW_RESP_OKAY));
      @(posedge CLK);
   endtask
   task automatic axr(input logic [3:0] a, input logic [31:0] e);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do @(negedge CLK); while (S_AXI_ARREADY !== 1'b1);
      @(posedge CLK);
      S_AXI_ARVALID <= 1'b0;
      do @(negedge CLK); while (S_AXI_RVALID !== 1'b1);
      chk(S_AXI_RDATA, e);
      chk(32'(S_AXI_RRESP), 32'(BSW_RESP_OKAY));
      @(posedge CLK);
   endtask
   // Lane 0 is bits 8:0, lane 1 bits 17:9; a high select keeps old data.
   function automatic logic [17:0] mrg(logic [17:0] o, logic [17:0] n,
         logic [1:0] s);
      return {s[1] ? o[17:9] : n[17:9], s[0] ? o[8:0] : n[8:0]};
   endfunction
   task automatic wr(input int a, input logic o, input logic [17:0] d0,
         input logic [1:0] s0, input logic [17:0] d1, input logic [1:0] s1,
         input logic [1:0] ex = 2'h0);
      mem[a][o] = mrg(mem[a][o], d0, s0);
      mem[a][!o] = mrg(mem[a][!o], d1, s1);
      ctl.burst(1'b0, 6'(a), o, ex, d0, s0, d1, s1);
   endtask
   task automatic rd(input int a, input logic o);
      expq.push_back(mem[a][o]);
      expq.push_back(mem[a][!o]);
      ctl.burst(1'b1, 6'(a), o, 2'h0, 18'h0, 2'h3, 18'h0, 2'h3);
   endtask
   task automatic drain();
      logic [17:0] e;
      while (expq.size() > 0) begin
         e = expq.pop_front();
         do @(negedge CLK); while (RD_VALID !== 1'b1);
         chk(32'(RD_DATA), 32'(e));
         @(posedge CLK);
         RD_READY <= 1'b1;
         @(posedge CLK);
         RD_READY <= 1'b0;
      end
   endtask
   ////////////////////////////////////////////////////////////////
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         give_verdict();
      end
   end
   initial begin
      repeat (8) @(posedge CLK);
      RST_B <= 1'b1;
      @(posedge CLK);
      axr(BSW_CTRL_OFS, BSW_CTRL_RST);
      axr(BSW_STATUS_OFS, 32'h0);
      $display("registers done");
      for (int a = 0; a < 4; a++) wr(a, a[0], 18'(a + 'h100), 2'h0,
         18'(a + 'h2f000), 2'h0);
      for (int a = 0; a < 4; a++) rd(a, a[1]);
      drain();
      $display("order done");
      // Each pair starts on an empty buffer so the bound checks can fire.
      wr(5, 1'b0, 18'h15a5a, 2'h0, 18'h0a5a5, 2'h0);
      rd(5, 1'b0);
      drain();
      wr(6, 1'b0, 18'h03333, 2'h0, 18'h3cccc, 2'h0);
      rd(6, 1'b1);
      drain();
      wr(7, 1'b1, 18'h21111, 2'h0, 18'h12222, 2'h0);
      rd(7, 1'b1);
      drain();
      $display("forwarding done");
      wr(5, 1'b1, 18'h3ffff, 2'h2, 18'h3ffff, 2'h1);
      rd(5, 1'b0);
      wr(5, 1'b0, 18'h00000, 2'h3, 18'h00000, 2'h3);
      rd(5, 1'b1);
      drain();
      $display("masking done");
      wr(9, 1'b0, 18'h00009, 2'h0, 18'h00090, 2'h0, 2'h1);
      // Let the write commit first, or the busy bit shows in the status.
      repeat (2) @(posedge CLK);
      axr(BSW_STATUS_OFS, 32'h2);
      axw(BSW_STATUS_OFS, 32'h2);
      axr(BSW_STATUS_OFS, 32'h0);
      axw(BSW_CTRL_OFS, 32'h0);
      @(negedge CLK);
      chk(32'(LOAD_READY), 32'h0);
      @(posedge CLK);
      axw(BSW_CTRL_OFS, 32'h1);
      $display("expansion and enable done");
      repeat (15) rd(9, 1'b0);
      // The last read's second word lands one edge after the call returns.
      @(posedge CLK);
      @(negedge CLK);
      chk(32'(LOAD_READY), 32'h0);
      @(posedge CLK);
      axr(BSW_STATUS_OFS, 32'h1e00);
      drain();
      @(negedge CLK);
      chk(32'(RD_VALID), 32'h0);
      @(posedge CLK);
      axr(BSW_WRCNT_OFS, 32'ha);
      axr(BSW_RDCNT_OFS, 32'h18);
      $display("buffer done");
      give_verdict();
   end
endmodule
`default_nettype wire

/* File: hw/bsw_pkg.sv */
// Constants and carrier types shared by the burst SRAM core and its bench.
// Assumes a single 250 MHz clock and an AXI4-Lite register master.
package bsw_pkg;

   // Register map, byte addresses on a 4-bit AXI4-Lite address.
   localparam int          BSW_AXI_AW     = 4;
   localparam logic [3:0]  BSW_CTRL_OFS   = 4'h0;
   localparam logic [3:0]  BSW_STATUS_OFS = 4'h4;
   localparam logic [3:0]  BSW_WRCNT_OFS  = 4'h8;
   localparam logic [3:0]  BSW_RDCNT_OFS  = 4'hc;

   // Field positions and reset values.
   localparam int          BSW_CTRL_EN_BIT = 0;
   localparam logic [31:0] BSW_CTRL_RST    = 32'h0000_0001;
   localparam int          BSW_ST_BUSY_BIT = 0;
   localparam int          BSW_ST_EXP_BIT  = 1;
   localparam int          BSW_ST_LVL_LSB  = 8;
   localparam logic [1:0]  BSW_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  BSW_RESP_SLVERR = 2'h2;

   // Array and buffer shape.
   localparam int          BSW_DATA_W     = 18;
   localparam int          BSW_LANE_W     = 9;
   localparam int          BSW_ADDR_W     = 6;
   localparam int          BSW_FIFO_DEPTH = 32;
   localparam int          BSW_ORDER_MIN_W = 18;

   // Clock period in ns; a K beat and its K-bar beat arrive on consecutive edges.
   localparam int          BSW_CLK_NS     = 4;
   localparam int          BSW_BEATS      = 2;

   typedef enum {
      BSW_IDLE,
      BSW_BEAT1
   } bsw_phase_e;

   // A latched AXI4-Lite write: address, data and strobes.
   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } bsw_axw_s;

   // A burst request held from its K beat to its K-bar beat.
   typedef struct packed {
      logic wr;
      logic order;
   } bsw_req_s;

endpackage

/* File: hw/bsw_top.sv */
// Burst-of-two SRAM core with lane write masks, burst ordering, write
// forwarding, a read-data FIFO and an AXI4-Lite register slave.
// Assumes all inputs are synchronous to CLK; the K beat and the K-bar beat
// of a burst arrive on two consecutive CLK edges.
//
// What this block does
// R1 - Sample lane selects on both burst beats.
// R2 - First-beat select gates first burst word.
// R3 - Second-beat select gates second burst word.
// R4 - Lane stored only while its select low.
// R5 - Low address bit orders the two words.
// R6 - Burst order only on wide configurations.
// R7 - Read right after write returns new data.
// R8 - Controller holds first expansion address low.
// R9 - Controller holds second expansion address low; the core checks EXPANSION_ADDR only on the K beat.
// R10 - Load low on K starts a burst.
// R11 - Read/write low writes, high reads.
// R12 - Nibble selects map to nibble lanes.
// R13 - Unselected lanes keep contents, forwarding too.
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module bsw_fifo #(
   parameter int W     = 18,
   parameter int DEPTH = 32
) (
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [W-1:0]               in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [W-1:0]                    out_data,
   output logic [$clog2(DEPTH):0]          level
);
   localparam int PW = $clog2(DEPTH);

   logic [W-1:0]  mem_q [DEPTH];
   logic [W-1:0]  mem_d [DEPTH];
   logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [PW:0]   cnt_q, cnt_d;
   logic          push, pop;

   assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];
   assign level     = cnt_q;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      mem_d = mem_q;
      wp_d  = wp_q;
      rp_d  = rp_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wp_q] = in_data;
         wp_d        = (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
         rp_d = (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      mem_q <= mem_d;
      if (!rst_b) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////

module bsw_top
   import bsw_pkg::*;
#(
   parameter int DATA_W = BSW_DATA_W,
   parameter int LANE_W = BSW_LANE_W,
   parameter int ADDR_W = BSW_ADDR_W,
   parameter int DEPTH  = BSW_FIFO_DEPTH
) (
   input  wire logic                   CLK,
   input  wire logic                   RST_B,
   input  wire logic [BSW_AXI_AW-1:0]  S_AXI_AWADDR,
   input  wire logic                   S_AXI_AWVALID,
   output logic                        S_AXI_AWREADY,
   input  wire logic [31:0]            S_AXI_WDATA,
   input  wire logic [3:0]             S_AXI_WSTRB,
   input  wire logic                   S_AXI_WVALID,
   output logic                        S_AXI_WREADY,
   output logic [1:0]                  S_AXI_BRESP,
   output logic                        S_AXI_BVALID,
   input  wire logic                   S_AXI_BREADY,
   input  wire logic [BSW_AXI_AW-1:0]  S_AXI_ARADDR,
   input  wire logic                   S_AXI_ARVALID,
   output logic                        S_AXI_ARREADY,
   output logic [31:0]                 S_AXI_RDATA,
   output logic [1:0]                  S_AXI_RRESP,
   output logic                        S_AXI_RVALID,
   input  wire logic                   S_AXI_RREADY,
   input  wire logic                   LOAD_REQUEST_N,
   input  wire logic                   READ_WRITE,
   input  wire logic [ADDR_W-1:0]      WORD_ADDRESS,
   input  wire logic                   BURST_ORDER_BIT,
   input  wire logic [1:0]             EXPANSION_ADDR,
   input  wire logic [DATA_W-1:0]      WRITE_DATA,
   input  wire logic [DATA_W/LANE_W-1:0] BYTE_WRITE_SELECT_N,
   output logic                        LOAD_READY,
   output logic [DATA_W-1:0]           RD_DATA,
   output logic                        RD_VALID,
   input  wire logic                   RD_READY
);
   localparam int LANES = DATA_W / LANE_W;
   localparam int MW    = 1 << (ADDR_W + 1);
   localparam int LW    = $clog2(DEPTH) + 1;

   // Merge new data into old under a bit mask; unmasked bits keep old.
   function automatic logic [DATA_W-1:0] merge(
      input logic [DATA_W-1:0] old_v,
      input logic [DATA_W-1:0] new_v,
      input logic [DATA_W-1:0] mask);
      merge = (old_v & ~mask) | (new_v & mask); // R13
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Lane masks: one select per lane, bytes or nibbles alike.

   logic [LANES-1:0]  sel0_q, sel0_d;
   logic [DATA_W-1:0] mask0, mask1;

   for (genvar l = 0; l < LANES; l++) begin : g_lane
      assign mask0[l*LANE_W +: LANE_W] = {LANE_W{~sel0_q[l]}};           // R4
      assign mask1[l*LANE_W +: LANE_W] = {LANE_W{~BYTE_WRITE_SELECT_N[l]}}; // R12
   end

   ////////////////////////////////////////////////////////////////////////////
   // Burst sequencer, array, forwarding and counters.

   bsw_phase_e        phase_q, phase_d;
   bsw_req_s          req_q, req_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] d0_q, d0_d;
   logic              wb_v_q, wb_v_d;
   logic [ADDR_W-1:0] wb_a_q, wb_a_d;
   logic [DATA_W-1:0] wb_dat_q [2];
   logic [DATA_W-1:0] wb_dat_d [2];
   logic [DATA_W-1:0] wb_msk_q [2];
   logic [DATA_W-1:0] wb_msk_d [2];
   logic [DATA_W-1:0] mem_q [MW];
   logic [DATA_W-1:0] mem_d [MW];
   logic [DATA_W-1:0] rw_q [2];
   logic [DATA_W-1:0] rw_d [2];
   logic              second_q, second_d;
   logic              exp_q, exp_d;
   logic [31:0]       wrcnt_q, wrcnt_d, rdcnt_q, rdcnt_d;
   logic              push;
   logic [DATA_W-1:0] push_data;
   logic              fifo_in_ready;
   logic [LW-1:0]     fifo_level;
   logic              take, order_in, en, exp_clr;
   logic [31:0]       ctrl_q;

   assign en         = ctrl_q[BSW_CTRL_EN_BIT];
   // Three slots are kept free so a taken read can always land both words.
   assign LOAD_READY = (phase_q == BSW_IDLE) && en && fifo_in_ready
                       && (fifo_level <= LW'(DEPTH - 3));
   assign take       = LOAD_READY && !LOAD_REQUEST_N;                   // R10
   assign order_in   = (DATA_W >= BSW_ORDER_MIN_W) ? BURST_ORDER_BIT
                                                   : 1'b0;              // R6

   always_comb begin
      phase_d  = phase_q;
      req_d    = req_q;
      addr_d   = addr_q;
      d0_d     = d0_q;
      sel0_d   = sel0_q;
      wb_v_d   = 1'b0;
      wb_a_d   = wb_a_q;
      wb_dat_d = wb_dat_q;
      wb_msk_d = wb_msk_q;
      mem_d    = mem_q;
      rw_d     = rw_q;
      second_d = 1'b0;
      push     = 1'b0;
      push_data = rw_q[~req_q.order];
      exp_d    = exp_q & ~exp_clr;
      wrcnt_d  = wrcnt_q;
      rdcnt_d  = rdcnt_q;
      if (wb_v_q) begin
         for (int w = 0; w < 2; w++) begin
            mem_d[{wb_a_q, 1'(w)}] = merge(mem_q[{wb_a_q, 1'(w)}],
                                           wb_dat_q[w], wb_msk_q[w]);
         end
      end
      if (second_q) begin
         push = 1'b1;
      end
      case (phase_q)
         BSW_IDLE: begin
            if (take) begin
               phase_d  = BSW_BEAT1;
               req_d.wr = ~READ_WRITE;                                  // R11
               req_d.order = order_in;
               addr_d   = WORD_ADDRESS;
               d0_d     = WRITE_DATA;
               sel0_d   = BYTE_WRITE_SELECT_N;                          // R1
               if (DATA_W >= BSW_ORDER_MIN_W && EXPANSION_ADDR != 2'h0) begin
                  exp_d = 1'b1;                                     // R8 R9
               end
               if (READ_WRITE) begin
                  rdcnt_d = rdcnt_q + 32'h1;
                  for (int w = 0; w < 2; w++) begin
                     rw_d[w] = mem_q[{WORD_ADDRESS, 1'(w)}];
                     if (wb_v_q && wb_a_q == WORD_ADDRESS) begin
                        rw_d[w] = merge(rw_d[w], wb_dat_q[w],
                                        wb_msk_q[w]);                   // R7
                     end
                  end
               end else begin
                  wrcnt_d = wrcnt_q + 32'h1;
               end
            end
         end
         BSW_BEAT1: begin
            phase_d = BSW_IDLE;
            if (req_q.wr) begin
               wb_v_d = 1'b1;
               wb_a_d = addr_q;
               wb_dat_d[req_q.order]  = d0_q;                           // R5
               wb_msk_d[req_q.order]  = mask0;                          // R2
               wb_dat_d[~req_q.order] = WRITE_DATA;
               wb_msk_d[~req_q.order] = mask1;                       // R1 R3
            end else begin
               push      = 1'b1;
               push_data = rw_q[req_q.order];                           // R5
               second_d  = 1'b1;
            end
         end
         default: phase_d = BSW_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      mem_q    <= mem_d;
      wb_dat_q <= wb_dat_d;
      wb_msk_q <= wb_msk_d;
      rw_q     <= rw_d;
      d0_q     <= d0_d;
      if (!RST_B) begin
         phase_q  <= BSW_IDLE;
         req_q    <= '0;
         addr_q   <= '0;
         sel0_q   <= '1;
         wb_v_q   <= 1'b0;
         wb_a_q   <= '0;
         second_q <= 1'b0;
         exp_q    <= 1'b0;
         wrcnt_q  <= 32'h0;
         rdcnt_q  <= 32'h0;
      end else begin
         phase_q  <= phase_d;
         req_q    <= req_d;
         addr_q   <= addr_d;
         sel0_q   <= sel0_d;
         wb_v_q   <= wb_v_d;
         wb_a_q   <= wb_a_d;
         second_q <= second_d;
         exp_q    <= exp_d;
         wrcnt_q  <= wrcnt_d;
         rdcnt_q  <= rdcnt_d;
      end
   end

   bsw_fifo #(
      .W     (DATA_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (CLK),
      .rst_b     (RST_B),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (push_data),
      .out_valid (RD_VALID),
      .out_ready (RD_READY),
      .out_data  (RD_DATA),
      .level     (fifo_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave. Address and data are taken in either order.

   bsw_axw_s    axw_q, axw_d;
   logic        aw_q, aw_d, w_q, w_d;
   logic        bv_q, bv_d, rv_q, rv_d;
   logic [1:0]  br_q, br_d, rr_q, rr_d;
   logic [31:0] rd_q, rd_d, ctrl_d, status;

   assign S_AXI_AWREADY = ~aw_q;
   assign S_AXI_WREADY  = ~w_q;
   assign S_AXI_BVALID  = bv_q;
   assign S_AXI_BRESP   = br_q;
   assign S_AXI_ARREADY = ~rv_q;
   assign S_AXI_RVALID  = rv_q;
   assign S_AXI_RRESP   = rr_q;
   assign S_AXI_RDATA   = rd_q;
   // A write of one clears the forbidden-expansion flag; a new event wins.
   assign exp_clr = aw_q && w_q && !bv_q && axw_q.addr == BSW_STATUS_OFS
                    && axw_q.strb[0] && axw_q.data[BSW_ST_EXP_BIT];

   always_comb begin
      status = 32'h0;
      status[BSW_ST_BUSY_BIT] = (phase_q != BSW_IDLE) | wb_v_q | second_q;
      status[BSW_ST_EXP_BIT]  = exp_q;
      status[BSW_ST_LVL_LSB +: 8] = 8'(fifo_level);
      axw_d  = axw_q;
      aw_d   = aw_q;
      w_d    = w_q;
      bv_d   = bv_q & ~S_AXI_BREADY;
      br_d   = br_q;
      ctrl_d = ctrl_q;
      rv_d   = rv_q & ~S_AXI_RREADY;
      rr_d   = rr_q;
      rd_d   = rd_q;
      if (S_AXI_AWVALID && !aw_q) begin
         aw_d       = 1'b1;
         axw_d.addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_q) begin
         w_d        = 1'b1;
         axw_d.data = S_AXI_WDATA;
         axw_d.strb = S_AXI_WSTRB;
      end
      if (aw_q && w_q && !bv_q) begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         bv_d = 1'b1;
         br_d = BSW_RESP_OKAY;
         case (axw_q.addr)
            BSW_CTRL_OFS: begin
               for (int b = 0; b < 4; b++) begin
                  if (axw_q.strb[b]) begin
                     ctrl_d[b*8 +: 8] = axw_q.data[b*8 +: 8];
                  end
               end
            end
            BSW_STATUS_OFS, BSW_WRCNT_OFS, BSW_RDCNT_OFS: br_d = BSW_RESP_OKAY;
            default: br_d = BSW_RESP_SLVERR;
         endcase
      end
      if (S_AXI_ARVALID && !rv_q) begin
         rv_d = 1'b1;
         rr_d = BSW_RESP_OKAY;
         case (S_AXI_ARADDR)
            BSW_CTRL_OFS:   rd_d = ctrl_q;
            BSW_STATUS_OFS: rd_d = status;
            BSW_WRCNT_OFS:  rd_d = wrcnt_q;
            BSW_RDCNT_OFS:  rd_d = rdcnt_q;
            default: begin
               rd_d = 32'h0;
               rr_d = BSW_RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         axw_q  <= '0;
         aw_q   <= 1'b0;
         w_q    <= 1'b0;
         bv_q   <= 1'b0;
         br_q   <= BSW_RESP_OKAY;
         ctrl_q <= BSW_CTRL_RST;
         rv_q   <= 1'b0;
         rr_q   <= BSW_RESP_OKAY;
         rd_q   <= 32'h0;
      end else begin
         axw_q  <= axw_d;
         aw_q   <= aw_d;
         w_q    <= w_d;
         bv_q   <= bv_d;
         br_q   <= br_d;
         ctrl_q <= ctrl_d;
         rv_q   <= rv_d;
         rr_q   <= rr_d;
         rd_q   <= rd_d;
      end
   end
endmodule

`default_nettype wire
